// >>> core/output_compare_pkg.sv
// Constants, field positions and carrier types for the output compare channel
package output_compare_pkg;

    // Register byte addresses on the APB slave
    localparam logic [7:0] ADDR_CONTROL_ONE = 8'h00;
    localparam logic [7:0] ADDR_CONTROL_TWO = 8'h04;
    localparam logic [7:0] ADDR_PRIMARY     = 8'h08;
    localparam logic [7:0] ADDR_SECONDARY   = 8'h0c;
    localparam logic [7:0] ADDR_PERIOD      = 8'h10;
    localparam logic [7:0] ADDR_TIMER       = 8'h14;

    // First control register fields
    localparam int IDLE_HALT_POS      = 13;
    localparam int TB_SEL_LSB         = 10;
    localparam int FAULT_EN_LSB       = 7;
    localparam int FAULT_FLAG_LSB     = 4;
    localparam int TRIG_CLR_MODE_POS  = 3;
    localparam int MODE_LSB           = 0;
    localparam logic [15:0] CONTROL_ONE_MASK  = 16'h3fff;
    localparam logic [15:0] CONTROL_ONE_RESET = 16'h0000;

    // Second control register fields (upper byte and trigger status)
    localparam int FAULT_CLEAR_MODE_POS  = 15;
    localparam int FAULT_DRIVE_LEVEL_POS = 14;
    localparam int FAULT_FLOAT_EN_POS    = 13;
    localparam int OUTPUT_INVERT_POS     = 12;
    localparam int TRIG_STATUS_POS       = 6;
    localparam logic [15:0] CONTROL_TWO_MASK  = 16'hf740;
    localparam logic [15:0] CONTROL_TWO_RESET = 16'h0000;

    localparam logic [15:0] COMPARE_RESET = 16'h0000;
    localparam logic [15:0] PERIOD_RESET  = 16'hffff;

    // Time base select codes
    localparam logic [2:0] TB_PERIPHERAL = 3'b111;
    localparam logic [2:0] TB_TIMER1     = 3'b100;
    localparam logic [2:0] TB_TIMER5     = 3'b011;

    typedef enum logic [2:0] {
        MODE_OFF         = 3'b000,
        MODE_SINGLE_HIGH = 3'b001,
        MODE_SINGLE_LOW  = 3'b010,
        MODE_TOGGLE      = 3'b011,
        MODE_DOUBLE_ONE  = 3'b100,
        MODE_DOUBLE_CONT = 3'b101,
        MODE_PWM_EDGE    = 3'b110,
        MODE_PWM_CENTER  = 3'b111
    } compare_mode_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } apb_rsp_t;

    typedef struct packed {
        apb_rsp_t    rsp;
        logic [15:0] control_one;
        logic [15:0] control_two;
        logic [15:0] primary;
        logic [15:0] secondary;
        logic [15:0] period;
        logic [15:0] primary_buf;
        logic [15:0] secondary_buf;
        logic [15:0] timer;
        logic        count_down;
        logic        shot_done;
        logic        out_level;
        logic        pin;
        logic        irq;
        logic [2:0]  sync1;
        logic [2:0]  sync2;
        logic [2:0]  sync3;
        logic [2:0]  fault_seen;
    } state_t;

endpackage : output_compare_pkg

// >>> core/output_compare_pwm_control.sv
// Output compare and PWM channel with APB register access
`timescale 1ns/100ps

module output_compare_pwm_control #(
    parameter int CHANNEL_NUM = 1
) (
    input  wire logic                         pclk,
    input  wire logic                         presetn,
    input  wire output_compare_pkg::apb_req_t apb_req,
    output      output_compare_pkg::apb_rsp_t apb_rsp,
    input  wire logic                         cpu_idle,
    input  wire logic [3:0]                   timer_ticks,
    input  wire logic                         timer1_tick,
    input  wire logic [2:0]                   comparator_out,
    input  wire logic                         fault_pin_a,
    input  wire logic                         fault_pin_b,
    output      logic                         compare_output_pin,
    output      logic                         compare_irq_flag,
    output      logic                         trigger_status
);

    localparam int CMP_IDX = (CHANNEL_NUM - 1) / 3;

    output_compare_pkg::state_t r;
    output_compare_pkg::state_t n;

    function automatic logic is_pwm(input logic [2:0] mode);
        is_pwm = (mode == output_compare_pkg::MODE_PWM_EDGE) || (mode == output_compare_pkg::MODE_PWM_CENTER);
    endfunction : is_pwm

    function automatic logic mapped(input logic [7:0] addr);
        mapped = (addr == output_compare_pkg::ADDR_CONTROL_ONE) || (addr == output_compare_pkg::ADDR_CONTROL_TWO)
              || (addr == output_compare_pkg::ADDR_PRIMARY) || (addr == output_compare_pkg::ADDR_SECONDARY)
              || (addr == output_compare_pkg::ADDR_PERIOD) || (addr == output_compare_pkg::ADDR_TIMER);
    endfunction : mapped

    logic        cmp_raw;
    logic [2:0]  mode;
    logic [2:0]  tb_sel;
    logic [2:0]  fault_en;
    logic        tick;
    logic        run;
    logic        at_period;
    logic        reload;
    logic        match_p;
    logic        match_s;
    logic [15:0] primary_eff;
    logic [15:0] secondary_eff;
    logic        wr;
    logic [2:0]  fault_event;
    logic        pwm_level;

    assign cmp_raw = comparator_out[CMP_IDX];

    always_comb begin
        n = r;
        n.rsp.pready = 1'b0;
        n.rsp.pslverr = 1'b0;
        n.irq = 1'b0;
        pwm_level = 1'b0;

        mode     = r.control_one[output_compare_pkg::MODE_LSB +: 3];
        tb_sel   = r.control_one[output_compare_pkg::TB_SEL_LSB +: 3];
        fault_en = r.control_one[output_compare_pkg::FAULT_EN_LSB +: 3];

        // Three-stage synchronisers, a change is taken once stages two and three agree
        n.sync1 = {cmp_raw, fault_pin_b, fault_pin_a};
        n.sync2 = r.sync1;
        n.sync3 = r.sync2;
        for (int i = 0; i < 3; i++) begin
            if (r.sync2[i] == r.sync3[i]) begin
                n.fault_seen[i] = r.sync3[i];
            end
        end

        // Time base selection
        case (tb_sel)
            output_compare_pkg::TB_PERIPHERAL: tick = 1'b1;
            output_compare_pkg::TB_TIMER1:     tick = timer1_tick;
            3'b000, 3'b001, 3'b010, output_compare_pkg::TB_TIMER5: tick = timer_ticks[tb_sel[1:0]];
            default:                           tick = 1'b0;
        endcase
        run = tick && (mode != output_compare_pkg::MODE_OFF)
            && !(r.control_one[output_compare_pkg::IDLE_HALT_POS] && cpu_idle);

        at_period     = (r.timer == r.period);
        reload        = run && at_period && is_pwm(mode);
        primary_eff   = is_pwm(mode) ? r.primary_buf : r.primary;
        secondary_eff = is_pwm(mode) ? r.secondary_buf : r.secondary;
        match_p       = run && (r.timer == primary_eff);
        match_s       = run && (r.timer == secondary_eff);

        // Channel timer
        if (run) begin
            if (mode == output_compare_pkg::MODE_PWM_CENTER) begin
                if (!r.count_down) begin
                    if (at_period) begin
                        n.count_down = 1'b1;
                        n.timer = (r.timer == 16'h0000) ? r.timer : r.timer - 16'h0001;
                    end else begin
                        n.timer = r.timer + 16'h0001;
                    end
                end else if (r.timer == 16'h0000) begin
                    n.count_down = 1'b0;
                    n.timer = at_period ? r.timer : r.timer + 16'h0001;
                end else begin
                    n.timer = r.timer - 16'h0001;
                end
            end else begin
                n.count_down = 1'b0;
                n.timer = at_period ? 16'h0000 : r.timer + 16'h0001;
            end
        end

        // Double-buffered duty values
        if (reload) begin
            n.primary_buf = r.primary;
            n.secondary_buf = r.secondary;
            n.irq = 1'b1;
        end

        // Output behaviour per mode
        case (mode)
            output_compare_pkg::MODE_SINGLE_HIGH: begin
                if (match_p && !r.shot_done) begin
                    n.out_level = 1'b1;
                    n.shot_done = 1'b1;
                end
                n.irq = match_p;
            end
            output_compare_pkg::MODE_SINGLE_LOW: begin
                if (match_p && !r.shot_done) begin
                    n.out_level = 1'b0;
                    n.shot_done = 1'b1;
                end
                n.irq = match_p;
            end
            output_compare_pkg::MODE_TOGGLE: begin
                if (match_p) begin
                    n.out_level = !r.out_level;
                end
                n.irq = match_p;
            end
            output_compare_pkg::MODE_DOUBLE_ONE: begin
                if (!r.shot_done) begin
                    if (match_p) begin
                        n.out_level = 1'b1;
                    end
                    if (match_s && r.out_level) begin
                        n.out_level = 1'b0;
                        n.shot_done = 1'b1;
                    end
                end
                n.irq = match_s;
            end
            output_compare_pkg::MODE_DOUBLE_CONT: begin
                if (match_p) begin
                    n.out_level = 1'b1;
                end
                if (match_s) begin
                    n.out_level = 1'b0;
                end
                n.irq = match_s;
            end
            output_compare_pkg::MODE_PWM_EDGE, output_compare_pkg::MODE_PWM_CENTER: begin
                if (mode == output_compare_pkg::MODE_PWM_CENTER) begin
                    pwm_level = (n.timer >= n.primary_buf);
                end else begin
                    pwm_level = (n.timer >= n.primary_buf) && (n.timer < n.secondary_buf);
                end
                if (n.secondary_buf > r.period) begin
                    pwm_level = 1'b1;
                end
                n.out_level = pwm_level;
            end
            default: begin
                n.out_level = 1'b0;
            end
        endcase

        // Register access: setup cycle answers on the next edge
        wr = apb_req.psel && apb_req.penable && apb_req.pwrite && r.rsp.pready && !r.rsp.pslverr;
        if (apb_req.psel && !apb_req.penable) begin
            n.rsp.pready = 1'b1;
            n.rsp.pslverr = !mapped(apb_req.paddr);
            n.rsp.prdata = 32'h0000_0000;
            case (apb_req.paddr)
                output_compare_pkg::ADDR_CONTROL_ONE: n.rsp.prdata[15:0] = r.control_one;
                output_compare_pkg::ADDR_CONTROL_TWO: n.rsp.prdata[15:0] = r.control_two;
                output_compare_pkg::ADDR_PRIMARY:     n.rsp.prdata[15:0] = r.primary;
                output_compare_pkg::ADDR_SECONDARY:   n.rsp.prdata[15:0] = r.secondary;
                output_compare_pkg::ADDR_PERIOD:      n.rsp.prdata[15:0] = r.period;
                output_compare_pkg::ADDR_TIMER:       n.rsp.prdata[15:0] = r.timer;
                default:                              n.rsp.prdata = 32'h0000_0000;
            endcase
        end

        // Hardware clear of trigger status comes first so a software set wins
        if (r.control_one[output_compare_pkg::TRIG_CLR_MODE_POS] && match_s) begin
            n.control_two[output_compare_pkg::TRIG_STATUS_POS] = 1'b0;
        end

        if (wr) begin
            case (apb_req.paddr)
                output_compare_pkg::ADDR_CONTROL_ONE: begin
                    n.control_one = apb_req.pwdata[15:0] & output_compare_pkg::CONTROL_ONE_MASK;
                    n.shot_done = 1'b0;
                    n.out_level = (apb_req.pwdata[2:0] == output_compare_pkg::MODE_SINGLE_LOW);
                end
                output_compare_pkg::ADDR_CONTROL_TWO: begin
                    n.control_two = apb_req.pwdata[15:0] & output_compare_pkg::CONTROL_TWO_MASK;
                end
                output_compare_pkg::ADDR_PRIMARY:   n.primary = apb_req.pwdata[15:0];
                output_compare_pkg::ADDR_SECONDARY: n.secondary = apb_req.pwdata[15:0];
                output_compare_pkg::ADDR_PERIOD:    n.period = apb_req.pwdata[15:0];
                default: begin
                end
            endcase
        end

        // Fault capture; hardware set wins over a software clear
        fault_event = r.fault_seen & fault_en;
        if (is_pwm(n.control_one[2:0])) begin
            n.control_one[output_compare_pkg::FAULT_FLAG_LSB +: 3] =
                n.control_one[output_compare_pkg::FAULT_FLAG_LSB +: 3] | fault_event;
            if (|n.control_one[output_compare_pkg::FAULT_FLAG_LSB +: 3]) begin
                n.out_level = n.control_two[output_compare_pkg::FAULT_DRIVE_LEVEL_POS];
            end
        end

        if (n.control_one[2:0] == output_compare_pkg::MODE_OFF) begin
            n.out_level = 1'b0;
        end
        n.pin = n.out_level ^ n.control_two[output_compare_pkg::OUTPUT_INVERT_POS];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r.rsp           <= '0;
            r.control_one   <= output_compare_pkg::CONTROL_ONE_RESET;
            r.control_two   <= output_compare_pkg::CONTROL_TWO_RESET;
            r.primary       <= output_compare_pkg::COMPARE_RESET;
            r.secondary     <= output_compare_pkg::COMPARE_RESET;
            r.period        <= output_compare_pkg::PERIOD_RESET;
            r.primary_buf   <= output_compare_pkg::COMPARE_RESET;
            r.secondary_buf <= output_compare_pkg::COMPARE_RESET;
            r.timer         <= output_compare_pkg::COMPARE_RESET;
            r.count_down    <= 1'b0;
            r.shot_done     <= 1'b0;
            r.out_level     <= 1'b0;
            r.pin           <= 1'b0;
            r.irq           <= 1'b0;
            r.sync1         <= 3'h0;
            r.sync2         <= 3'h0;
            r.sync3         <= 3'h0;
            r.fault_seen    <= 3'h0;
        end else begin
            r <= n;
        end
    end

    assign apb_rsp            = r.rsp;
    assign compare_output_pin = r.pin;
    assign compare_irq_flag   = r.irq;
    assign trigger_status     = r.control_two[output_compare_pkg::TRIG_STATUS_POS];

endmodule : output_compare_pwm_control

// >>> testbench/output_compare_assertions.sv
// Port-level checks for the output compare channel
`timescale 1ns/100ps
module output_compare_assertions #(
    parameter int CHANNEL_NUM = 1
) (
    input wire logic                         pclk,
    input wire logic                         presetn,
    input wire output_compare_pkg::apb_req_t apb_req,
    input wire output_compare_pkg::apb_rsp_t apb_rsp,
    input wire logic                         cpu_idle,
    input wire logic [3:0]                   timer_ticks,
    input wire logic                         timer1_tick,
    input wire logic [2:0]                   comparator_out,
    input wire logic                         fault_pin_a,
    input wire logic                         fault_pin_b,
    input wire logic                         compare_output_pin,
    input wire logic                         compare_irq_flag,
    input wire logic                         trigger_status
);
    logic [15:0] con1_reg;
    logic        inv_reg;
    logic        start_reg;
    logic        wr_one;
    logic        wr_two;
    assign wr_one = apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite
        && apb_req.paddr == output_compare_pkg::ADDR_CONTROL_ONE;
    assign wr_two = apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite
        && apb_req.paddr == output_compare_pkg::ADDR_CONTROL_TWO;
    // Shadow of software-owned control bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            con1_reg  <= 16'h0000;
            inv_reg   <= 1'b0;
            start_reg <= 1'b0;
        end else begin
            if (wr_one) begin
                con1_reg  <= apb_req.pwdata[15:0];
                start_reg <= (apb_req.pwdata[2:0] == 3'b010) ^ inv_reg;
            end
            if (wr_two) begin
                inv_reg <= apb_req.pwdata[12];
            end
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_READY_AFTER_SETUP: assert property (apb_req.psel && !apb_req.penable |=> apb_rsp.pready)
        else $error("pready missing after setup");
    AST_READY_PULSE: assert property (apb_rsp.pready |=> !apb_rsp.pready)
        else $error("pready longer than one cycle");
    AST_UNMAPPED_ERR: assert property (apb_req.psel && !apb_req.penable && apb_req.paddr > 8'h14
        |=> apb_rsp.pslverr && apb_rsp.prdata == 32'h00000000) else $error("unmapped access not refused");
    AST_CON1_TOP_ZERO: assert property (apb_rsp.pready && !apb_req.pwrite
        && apb_req.paddr == output_compare_pkg::ADDR_CONTROL_ONE |-> apb_rsp.prdata[31:14] == 18'h00000)
        else $error("control one top bits not zero");
    AST_TRIG_RISE: assert property ($rose(trigger_status) |-> $past(wr_two && apb_req.pwdata[6]))
        else $error("trigger status set without write");
    AST_TRIG_FALL: assert property ($fell(trigger_status) |-> $past(wr_two) || $past(con1_reg[3]))
        else $error("trigger status cleared by hardware in software mode");
    AST_OFF_QUIET: assert property ($past(con1_reg[2:0]) == 3'b000 |-> !compare_irq_flag)
        else $error("interrupt while channel off");
    AST_IDLE_HALT: assert property ($past(con1_reg[13] && cpu_idle) |-> !compare_irq_flag)
        else $error("interrupt while halted in idle");
    AST_RESERVED_TB: assert property ($past(con1_reg[12:10] == 3'b110 || con1_reg[12:10] == 3'b101)
        |-> !compare_irq_flag) else $error("interrupt with reserved time base");
    AST_START_LEVEL: assert property (wr_one && apb_req.pwdata[12:10] == 3'b101
        && apb_req.pwdata[2:0] inside {3'b001, 3'b010, 3'b100, 3'b101} |-> ##[1:2] compare_output_pin == start_reg)
        else $error("wrong start level");
    COV_PWM: cover property (wr_one && apb_req.pwdata[2:0] == 3'b110);
    COV_TRIG_FALL: cover property ($fell(trigger_status));
    COV_ERR: cover property (apb_rsp.pslverr);
endmodule : output_compare_assertions

bind output_compare_pwm_control output_compare_assertions #(.CHANNEL_NUM(CHANNEL_NUM)) u_checker (
    .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp), .cpu_idle(cpu_idle),
    .timer_ticks(timer_ticks), .timer1_tick(timer1_tick), .comparator_out(comparator_out),
    .fault_pin_a(fault_pin_a), .fault_pin_b(fault_pin_b), .compare_output_pin(compare_output_pin),
    .compare_irq_flag(compare_irq_flag), .trigger_status(trigger_status));

// >>> testbench/fault_source_model.sv
// Fault pins and comparator outputs seen by the channel
`timescale 1ns/100ps
module fault_source_model #(
    parameter int CHANNEL_NUM = 1
) (
    input  wire logic       pclk,
    input  wire logic [2:0] fault_req,
    output      logic       fault_pin_a,
    output      logic       fault_pin_b,
    output      logic [2:0] comparator_out
);
    localparam int GROUP = (CHANNEL_NUM - 1) / 3;
    initial begin
        fault_pin_a    = 1'b0;
        fault_pin_b    = 1'b0;
        comparator_out = 3'b010;
    end
    always @(posedge pclk) begin
        fault_pin_a <= fault_req[0];
        fault_pin_b <= fault_req[1];
        // Comparators of other groups toggle every cycle
        for (int i = 0; i < 3; i++) begin
            comparator_out[i] <= (i == GROUP) ? fault_req[2] : ~comparator_out[i];
        end
    end
endmodule : fault_source_model

// >>> testbench/output_compare_pwm_control_tb_top.sv
// Self-checking bench for the output compare channel
`timescale 1ns/100ps
module output_compare_pwm_control_tb_top;
    localparam int WIN = 210;
    typedef struct {logic [2:0] m; int s; int e; int i; int h;} row_t;
    row_t rows [8] = '{'{0, 0, 0, 0, 0}, '{1, 1, 1, -1, -1}, '{2, 1, 1, -1, -1}, '{3, 1, 10, 10, -1},
        '{4, 1, 2, 10, 7}, '{5, 21, 20, 10, 70}, '{6, 45, 20, -1, 70}, '{7, 45, -1, -1, -1}};
    logic [7:0]  addr [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};
    logic [31:0] rexp [6] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0000ffff, 32'h0};
    logic                         pclk = 1'b0;
    logic                         presetn = 1'b0;
    output_compare_pkg::apb_req_t apb_req = '0;
    output_compare_pkg::apb_rsp_t apb_rsp;
    logic                         cpu_idle = 1'b0;
    logic [3:0]                   timer_ticks = 4'h0;
    logic                         timer1_tick = 1'b0;
    logic [2:0]                   comparator_out;
    logic                         fault_pin_a;
    logic                         fault_pin_b;
    logic                         compare_output_pin;
    logic                         compare_irq_flag;
    logic                         trigger_status;
    logic [2:0]                   fault_req = 3'h0;
    logic [4:0]                   tick_mask = 5'h00;
    logic [31:0]                  rd;
    logic                         err;
    logic                         pin_q = 1'b0;
    int failures = 0, cmp_count = 0, cycles = 0, edges = 0, irqs = 0, highs = 0, e0, i0, h0;
    always #2.5 pclk = ~pclk;
    output_compare_pwm_control #(.CHANNEL_NUM(5)) u_dut (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
        .apb_rsp(apb_rsp), .cpu_idle(cpu_idle), .timer_ticks(timer_ticks), .timer1_tick(timer1_tick),
        .comparator_out(comparator_out), .fault_pin_a(fault_pin_a), .fault_pin_b(fault_pin_b),
        .compare_output_pin(compare_output_pin), .compare_irq_flag(compare_irq_flag),
        .trigger_status(trigger_status));
    fault_source_model #(.CHANNEL_NUM(5)) u_load (.pclk(pclk), .fault_req(fault_req),
        .fault_pin_a(fault_pin_a), .fault_pin_b(fault_pin_b), .comparator_out(comparator_out));
    always @(posedge pclk) begin
        timer_ticks <= 4'($urandom) & tick_mask[3:0];
        timer1_tick <= 1'($urandom) & tick_mask[4];
        cycles++;
        if (cycles > 30000) begin
            failures++;
            complete_run();
        end
    end
    always @(negedge pclk) begin
        edges += (compare_output_pin !== pin_q);
        irqs += (compare_irq_flag === 1'b1);
        highs += (compare_output_pin === 1'b1);
        pin_q = compare_output_pin;
    end
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (apb_rsp.pready !== 1'b1);
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask : xfer
    // Load the mode with the time base frozen, then start it and count a window
    task automatic run(input logic [15:0] c1, input int settle);
        xfer(addr[0], 1'b1, {16'h0000, c1 & 16'he3ff | 16'h1400});
        xfer(addr[0], 1'b1, {16'h0000, c1});
        repeat (settle) @(posedge pclk);
        e0 = edges; i0 = irqs; h0 = highs;
        repeat (WIN) @(posedge pclk);
        e0 = edges - e0; i0 = irqs - i0; h0 = highs - h0;
    endtask : run
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : complete_run
    initial begin
        logic [31:0] v;
        logic [2:0]  tb;
        void'($urandom(32'h54c4));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        foreach (addr[k]) begin
            xfer(addr[k], 1'b0, 32'h0);
            check("reset value", rd, rexp[k]);
        end
        // Halted in idle so the all-ones mode does not move the timer
        cpu_idle <= 1'b1;
        xfer(addr[0], 1'b1, 32'hffffffff);
        xfer(addr[0], 1'b0, 32'h0);
        check("control one mask", rd, 32'h00003fff);
        xfer(addr[0], 1'b1, 32'h0);
        cpu_idle <= 1'b0;
        xfer(8'h18, 1'b0, 32'h0);
        check("unmapped error", {31'h0, err}, 32'h1);
        for (int k = 0; k < 4; k++) begin
            v = $urandom;
            xfer(addr[2 + k % 2], 1'b1, v);
            xfer(addr[2 + k % 2], 1'b0, 32'h0);
            check("compare value", rd, {16'h0000, v[15:0]});
        end
        xfer(addr[5], 1'b1, 32'h1234);
        xfer(addr[5], 1'b0, 32'h0);
        check("timer read only", rd, 32'h0);
        $display("test registers done");
        xfer(addr[2], 1'b1, 32'd5);
        xfer(addr[3], 1'b1, 32'd12);
        xfer(addr[4], 1'b1, 32'd20);
        foreach (rows[k]) begin
            run({6'h07, 7'h00, rows[k].m}, rows[k].s);
            if (rows[k].e >= 0) check("edges", 32'(e0), 32'(rows[k].e));
            if (rows[k].i >= 0) check("irqs", 32'(i0), 32'(rows[k].i));
            if (rows[k].h >= 0) check("high cycles", 32'(h0), 32'(rows[k].h));
            if (rows[k].m == 3'b111) check("center shape", 32'(h0 > 0 && h0 < WIN && e0 > 0), 32'h1);
        end
        run(16'h1c04, 0);
        check("one shot rearmed", 32'(e0), 32'd2);
        $display("test modes done");
        xfer(addr[3], 1'b1, 32'd25);
        run(16'h1c06, 45);
        check("full duty", 32'(h0), 32'(WIN));
        for (int s = 0; s < 3; s++) begin
            for (int en = 0; en < 2; en++) begin
                xfer(addr[0], 1'b1, {16'h0000, 16'h1c06 | 16'(en << (7 + s))});
                fault_req <= 3'(1 << s);
                repeat (12) @(posedge pclk);
                check("fault pin level", {31'h0, compare_output_pin}, 32'(en == 0));
                xfer(addr[0], 1'b0, 32'h0);
                check("fault flags", {29'h0, rd[6:4]}, 32'(en << s));
                fault_req <= 3'h0;
                repeat (12) @(posedge pclk);
            end
        end
        xfer(addr[0], 1'b1, 32'h1f83);
        fault_req <= 3'h7;
        repeat (12) @(posedge pclk);
        xfer(addr[0], 1'b0, 32'h0);
        check("flags outside pwm", {29'h0, rd[6:4]}, 32'h0);
        fault_req <= 3'h0;
        xfer(addr[3], 1'b1, 32'd12);
        $display("test faults done");
        for (int k = 0; k < 3; k++) begin
            cpu_idle <= (k != 1);
            run(k == 2 ? 16'h1c03 : 16'h3c03, 1);
            check("idle edges", 32'(e0), k == 0 ? 32'h0 : 32'd10);
        end
        cpu_idle <= 1'b0;
        for (int k = 0; k < 7; k++) begin
            tb = 3'(k);
            tick_mask <= (k > 4) ? 5'h1f : 5'(1 << k);
            run({3'b000, tb, 10'h003}, 0);
            check("selected ticks", 32'(e0 != 0), 32'(k < 5));
            tick_mask <= 5'h1f ^ 5'(1 << k);
            if (k < 5) run({3'b000, tb, 10'h003}, 0);
            if (k < 5) check("other ticks", 32'(e0), 32'h0);
        end
        $display("test time base done");
        xfer(addr[1], 1'b1, 32'h40);
        run(16'h1c03, 0);
        check("trigger kept", {31'h0, trigger_status}, 32'h1);
        run(16'h1c0b, 0);
        check("trigger cleared", {31'h0, trigger_status}, 32'h0);
        xfer(addr[0], 1'b1, 32'h0);
        xfer(addr[1], 1'b1, 32'h40);
        xfer(addr[1], 1'b1, 32'h0);
        @(posedge pclk);
        check("trigger software clear", {31'h0, trigger_status}, 32'h0);
        $display("test trigger done");
        complete_run();
    end
endmodule : output_compare_pwm_control_tb_top
